// file: design/urf_rx_status.v
// serial receiver with status flags, clear sequences and apb registers
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "urf_consts.vh"

// Behaviour
// - buffer-full flag sets when a finished character moves into the buffer.
// - buffer-full clears by status read with flag set, then data read.
// - idle flag sets after one character time (10 or 11 bits) of high line.
// - start-bit mode counts idle from after the start bit, stop bit included.
// - stop-bit mode counts idle only after the stop bit.
// - idle flag clears by status read with flag set, then data read.
// - after clearing, idle sets again only after a new buffer-full set.
// - overrun sets when a character arrives unread buffer; new one is dropped.
// - overrun clears by status read with flag set, then data read.
// - seven samples in the start bit, three in each data and stop bit.
// - any disagreeing sample in a frame sets noise with buffer-full.
// - noise clears by status read, then data read.
// - low stop bit sets framing error together with buffer-full.
// - framing error clears by status read with flag set, then data read.
// - enabled parity mismatch sets parity error with buffer-full.
// - parity error clears by status read, then data read.
module urf_rx_status (
   input wire CLOCK_IN,
   input wire SYS_RST_IN,
   input wire PSEL_IN,
   input wire PENABLE_IN,
   input wire PWRITE_IN,
   input wire [7:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   output wire [31:0] PRDATA_OUT,
   output wire PREADY_OUT,
   output wire PSLVERR_OUT,
   input wire RXD_IN,
   output wire IRQ_OUT
);

   localparam ST_IDLE = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_STOP = 2'h3;

   // majority of three samples
   function maj3;
      input [2:0] s;
      begin
         maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
      end
   endfunction

   // true when the samples of one bit do not all agree
   function disagree;
      input [6:0] s;
      input start;
      begin
         if (start)
            disagree = (s != 7'h00) && (s != 7'h7F);
         else
            disagree = (s[2:0] != 3'h0) && (s[2:0] != 3'h7);
      end
   endfunction

   // number of high samples among seven
   function [2:0] ones7;
      input [6:0] s;
      integer i;
      begin
         ones7 = 3'h0;
         for (i = 0; i < 7; i = i + 1) begin
            ones7 = ones7 + {2'h0, s[i]};
         end
      end
   endfunction

   reg rx_s_reg;
   reg [12:0] div_cnt_reg;
   reg [1:0] state_reg;
   reg [3:0] phase_reg;
   reg [3:0] bit_cnt_reg;
   reg [6:0] samp_reg;
   reg [8:0] shift_reg;
   reg noise_acc_reg;
   reg par_acc_reg;
   reg [7:0] idle_cnt_reg;
   reg idle_arm_reg;
   reg rx_buffer_full_flag_reg;
   reg idle_reg;
   reg ovr_reg;
   reg nf_reg;
   reg fe_reg;
   reg pf_reg;
   reg [8:0] data_reg;
   reg [5:0] armed_reg;
   reg [4:0] ctrl_reg;
   reg [12:0] baud_reg;
   reg [5:0] int_stat_reg;
   reg [5:0] int_mask_reg;
   reg irq_reg;
   reg [31:0] prdata_reg;
   reg ready_reg;
   reg slverr_reg;

   reg [31:0] rd_mux;
   reg rd_mapped;

   wire par_en = ctrl_reg[`URF_CTRL_PAR_EN];
   wire par_odd = ctrl_reg[`URF_CTRL_PAR_ODD];
   wire nine = ctrl_reg[`URF_CTRL_NINE];
   wire quiet_count_start_select = ctrl_reg[`URF_CTRL_QSTOP];
   wire rx_en = ctrl_reg[`URF_CTRL_RX_EN];

   // oversampling tick, sixteen per bit time
   wire tick = (div_cnt_reg == 13'h0000);
   wire is_start = (state_reg == ST_START);
   wire bit_end = tick && (phase_reg == `URF_TICK_LAST);
   wire in_win = is_start ?
      (phase_reg >= `URF_START_FIRST && phase_reg <= `URF_START_LAST) :
      (phase_reg >= `URF_BIT_FIRST && phase_reg <= `URF_BIT_LAST);
   wire bit_val = maj3(samp_reg[2:0]);
   wire bit_noisy = disagree(samp_reg, is_start);
   wire [3:0] last_bit = nine ? 4'h8 : 4'h7;

   // end of the stop bit: a character is ready for the buffer
   wire frame_done = bit_end && (state_reg == ST_STOP);
   wire fr_noise = noise_acc_reg | bit_noisy;
   wire fr_ferr = ~bit_val;
   wire fr_perr = par_en & (par_acc_reg ^ par_odd);
   wire [8:0] fr_data = nine ? shift_reg : {1'b0, shift_reg[8:1]};

   // apb access phase, taken at the edge where pready is high
   wire apb_acc = PSEL_IN && PENABLE_IN && ready_reg;
   wire apb_rd = apb_acc && !PWRITE_IN;
   wire apb_wr = apb_acc && PWRITE_IN;
   wire rd_stat = apb_rd && (PADDR_IN == `URF_OFF_STATUS);
   wire rd_data = apb_rd && (PADDR_IN == `URF_OFF_DATA);
   wire rd_int = apb_rd && (PADDR_IN == `URF_OFF_INT_STAT);

   wire [5:0] clr = rd_data ? armed_reg : 6'h00;

   wire load = frame_done && (!rx_buffer_full_flag_reg || clr[`URF_BIT_RX_BUFFER_FULL_FLAG]);
   wire ovr_set = frame_done && !load;

   wire [7:0] idle_target = nine ? `URF_IDLE_LONG : `URF_IDLE_SHORT;
   // stop-bit mode keeps the count cleared to zero during the whole frame
   wire idle_hold = quiet_count_start_select && (state_reg != ST_IDLE);
   // one character time of high line
   wire idle_hit = tick && rx_s_reg && !idle_hold &&
      (idle_cnt_reg == idle_target - 8'h01);
   wire idle_set = idle_hit && idle_arm_reg;

   wire [5:0] status = {rx_buffer_full_flag_reg, idle_reg, ovr_reg, nf_reg, fe_reg, pf_reg};
   wire [5:0] events = {load, idle_set, ovr_set, load & fr_noise,
      load & fr_ferr, load & fr_perr};
   wire [5:0] int_clr = rd_int ? prdata_reg[5:0] : 6'h00;
   // set wins over a read clear
   wire [5:0] int_stat_next = events | (int_stat_reg & ~int_clr);

   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         rx_s_reg <= 1'b1;
         div_cnt_reg <= 13'h0000;
      end else begin
         rx_s_reg <= RXD_IN;
         if (tick)
            div_cnt_reg <= (baud_reg == 13'h0000) ? 13'h0000 :
               baud_reg - 13'h0001;
         else
            div_cnt_reg <= div_cnt_reg - 13'h0001;
      end
   end

   // frame receiver
   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         state_reg <= ST_IDLE;
         phase_reg <= 4'h0;
         bit_cnt_reg <= 4'h0;
         samp_reg <= 7'h00;
         shift_reg <= 9'h000;
         noise_acc_reg <= 1'b0;
         par_acc_reg <= 1'b0;
      end else if (!rx_en) begin
         state_reg <= ST_IDLE;
         phase_reg <= 4'h0;
         samp_reg <= 7'h00;
      end else if (tick) begin
         if (state_reg != ST_IDLE) begin
            phase_reg <= phase_reg + 4'h1;
         end
         if (bit_end)
            samp_reg <= 7'h00;
         else if (state_reg != ST_IDLE && in_win)
            samp_reg <= {samp_reg[5:0], rx_s_reg};
         case (state_reg)
            ST_IDLE: begin
               // a low line at a tick opens a possible start bit
               if (!rx_s_reg) begin
                  state_reg <= ST_START;
                  phase_reg <= 4'h1;
                  samp_reg <= 7'h00;
               end
            end
            ST_START: begin
               if (bit_end) begin
                  // a mostly high start bit is a glitch, not a frame
                  if (ones7(samp_reg) >= 3'h4) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg <= ST_DATA;
                     bit_cnt_reg <= 4'h0;
                     noise_acc_reg <= bit_noisy;
                     par_acc_reg <= 1'b0;
                  end
               end
            end
            ST_DATA: begin
               if (bit_end) begin
                  shift_reg <= {bit_val, shift_reg[8:1]};
                  par_acc_reg <= par_acc_reg ^ bit_val;
                  noise_acc_reg <= noise_acc_reg | bit_noisy;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == last_bit)
                     state_reg <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (bit_end)
                  state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // idle line counter in ticks, saturating at one character time
   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         idle_cnt_reg <= 8'h00;
      end else if (!rx_s_reg || idle_hold) begin
         // any low sample restarts the count; high data bits count in start-bit mode only
         idle_cnt_reg <= 8'h00;
      end else if (tick && idle_cnt_reg != idle_target) begin
         idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
   end

   // status flags and receive buffer
   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         rx_buffer_full_flag_reg <= 1'b0;
         idle_reg <= 1'b0;
         ovr_reg <= 1'b0;
         nf_reg <= 1'b0;
         fe_reg <= 1'b0;
         pf_reg <= 1'b0;
         data_reg <= 9'h000;
         armed_reg <= 6'h00;
         idle_arm_reg <= 1'b0;
      end else begin
         rx_buffer_full_flag_reg <= load | (rx_buffer_full_flag_reg & ~clr[`URF_BIT_RX_BUFFER_FULL_FLAG]);
         idle_reg <= idle_set | (idle_reg & ~clr[`URF_BIT_IDLE]);
         ovr_reg <= ovr_set | (ovr_reg & ~clr[`URF_BIT_OVR]);
         nf_reg <= (load & fr_noise) | (nf_reg & ~clr[`URF_BIT_NOISE]);
         fe_reg <= (load & fr_ferr) | (fe_reg & ~clr[`URF_BIT_FERR]);
         pf_reg <= (load & fr_perr) | (pf_reg & ~clr[`URF_BIT_PERR]);
         if (load)
            data_reg <= fr_data;
         // rearm idle detection on a new character
         if (load)
            idle_arm_reg <= 1'b1;
         else if (idle_set)
            idle_arm_reg <= 1'b0;
         // arm the flags software saw set
         if (rd_stat)
            armed_reg <= prdata_reg[5:0] & status;
         else if (rd_data)
            armed_reg <= 6'h00;
      end
   end

   // control registers and interrupt
   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         ctrl_reg <= `URF_CTRL_RST;
         baud_reg <= `URF_BAUD_RST;
         int_mask_reg <= `URF_MASK_RST;
         int_stat_reg <= 6'h00;
         irq_reg <= 1'b0;
      end else begin
         if (apb_wr && PADDR_IN == `URF_OFF_CTRL)
            ctrl_reg <= PWDATA_IN[4:0];
         if (apb_wr && PADDR_IN == `URF_OFF_BAUD)
            baud_reg <= PWDATA_IN[12:0];
         if (apb_wr && PADDR_IN == `URF_OFF_INT_MASK)
            int_mask_reg <= PWDATA_IN[5:0];
         int_stat_reg <= int_stat_next;
         irq_reg <= |(int_stat_next & int_mask_reg);
      end
   end

   // read data, captured in the setup cycle
   always @* begin
      rd_mux = 32'h00000000;
      rd_mapped = 1'b1;
      case (PADDR_IN)
         `URF_OFF_STATUS: rd_mux = {26'h0000000, status};
         `URF_OFF_DATA: rd_mux = {23'h000000, data_reg};
         `URF_OFF_CTRL: rd_mux = {27'h0000000, ctrl_reg};
         `URF_OFF_BAUD: rd_mux = {19'h00000, baud_reg};
         `URF_OFF_INT_STAT: rd_mux = {26'h0000000, int_stat_reg};
         `URF_OFF_INT_MASK: rd_mux = {26'h0000000, int_mask_reg};
         default: rd_mapped = 1'b0;
      endcase
   end

   // one wait-free access phase; the answer is registered so the bus
   // outputs stay glitch free, the cost is a read value one cycle old
   always @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         ready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         slverr_reg <= 1'b0;
      end else if (PSEL_IN && !PENABLE_IN) begin
         ready_reg <= 1'b1;
         prdata_reg <= PWRITE_IN ? 32'h00000000 : rd_mux;
         slverr_reg <= !rd_mapped;
      end else begin
         ready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         slverr_reg <= 1'b0;
      end
   end

   assign PRDATA_OUT = prdata_reg;
   assign PREADY_OUT = ready_reg;
   assign PSLVERR_OUT = slverr_reg;
   assign IRQ_OUT = irq_reg;

endmodule

// file: design/urf_consts.vh
// constants for the serial receive status flag block
`ifndef URF_CONSTS_VH
`define URF_CONSTS_VH

// register byte offsets on the apb bus
`define URF_OFF_STATUS    8'h00
`define URF_OFF_DATA      8'h04
`define URF_OFF_CTRL      8'h08
`define URF_OFF_BAUD      8'h0C
`define URF_OFF_INT_STAT  8'h10
`define URF_OFF_INT_MASK  8'h14

// status flag positions, shared by status, int status and int mask
`define URF_BIT_RX_BUFFER_FULL_FLAG      5
`define URF_BIT_IDLE      4
`define URF_BIT_OVR       3
`define URF_BIT_NOISE     2
`define URF_BIT_FERR      1
`define URF_BIT_PERR      0

// control register fields
`define URF_CTRL_PAR_EN   0
`define URF_CTRL_PAR_ODD  1
`define URF_CTRL_NINE     2
`define URF_CTRL_QSTOP    3
`define URF_CTRL_RX_EN    4

// reset values
`define URF_CTRL_RST      5'h10
`define URF_BAUD_RST      13'h000D
`define URF_MASK_RST      6'h00

// oversampling: ticks per bit and sample windows
`define URF_TICK_LAST     4'hF
`define URF_START_FIRST   4'h3
`define URF_START_LAST    4'h9
`define URF_BIT_FIRST     4'h7
`define URF_BIT_LAST      4'h9

// idle line length in ticks: 10 or 11 bit times of 16 ticks
`define URF_IDLE_SHORT    8'hA0
`define URF_IDLE_LONG     8'hB0

`endif

// file: testbench/urf_rx_status_props.sv
// bus timing and status invariants of the receive status flag block
`timescale 1ns/1ps
`include "urf_consts.vh"
module urf_rx_status_props (
   input wire CLOCK_IN,
   input wire SYS_RST_IN,
   input wire PSEL_IN,
   input wire PENABLE_IN,
   input wire PWRITE_IN,
   input wire [7:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   input wire [31:0] PRDATA_OUT,
   input wire PREADY_OUT,
   input wire PSLVERR_OUT,
   input wire RXD_IN,
   input wire IRQ_OUT
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (SYS_RST_IN);
   sequence s_setup;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence s_answer;
      PREADY_OUT && PSEL_IN && PENABLE_IN;
   endsequence
   sequence s_stat_rd;
      s_answer ##0 (!PWRITE_IN && PADDR_IN == `URF_OFF_STATUS);
   endsequence
   a_ready_after_setup: assert property (s_setup |=> PREADY_OUT)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
      else $error("ready outside access");
   a_rdata_idle_zero: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
      else $error("read data outside answer");
   a_unmapped_err: assert property (s_answer ##0 (PADDR_IN > 8'h14)
      |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_err: assert property (s_answer ##0 (PADDR_IN <= 8'h14
      && PADDR_IN[1:0] == 2'h0) |-> !PSLVERR_OUT)
      else $error("mapped access refused");
   a_status_upper_zero: assert property (s_stat_rd
      |-> PRDATA_OUT[31:6] == 26'h0)
      else $error("status upper bits set");
   a_errors_with_full: assert property (
      s_stat_rd ##0 (PRDATA_OUT[2:0] != 3'h0) |-> PRDATA_OUT[5])
      else $error("error flag without buffer full");
endmodule

bind urf_rx_status urf_rx_status_props u_props (.CLOCK_IN(CLOCK_IN),
   .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
   .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .RXD_IN(RXD_IN), .IRQ_OUT(IRQ_OUT));

// file: testbench/urf_serial_src.sv
// remote serial transmitter model, 8 data bits, 16 clocks a bit
`timescale 1ns/1ps
module urf_serial_src (
   input wire CLOCK_IN,
   input wire go_in,
   input wire [7:0] frame_in,
   input wire stop_low_in,
   input wire glitch_in,
   output reg RXD_OUT = 1'b1,
   output reg busy_out = 1'b0
);
   integer cnt = 0;
   function automatic logic lvl(input integer k);
      integer b;
      begin
         b = k / 16;
         if (b == 0) lvl = 1'b0;
         else if (b <= 8) lvl = frame_in[b - 1];
         else lvl = !stop_low_in;
         // one odd sample in the middle of the first data bit
         if (glitch_in && b == 1 && k % 16 == 7) lvl = !lvl;
      end
   endfunction
   // line returns to mark level between frames
   always @(posedge CLOCK_IN) begin
      if (!busy_out && go_in) begin
         busy_out <= 1'b1;
         cnt <= 0;
         RXD_OUT <= 1'b0;
      end else if (busy_out && cnt == 159) begin
         busy_out <= 1'b0;
         RXD_OUT <= 1'b1;
      end else if (busy_out) begin
         cnt <= cnt + 1;
         RXD_OUT <= lvl(cnt + 1);
      end
   end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the receive status flag block
`timescale 1ns/1ps
`include "urf_consts.vh"
module testbench;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} urf_exp_t;
   reg CLOCK_IN = 1'b0;
   reg SYS_RST_IN = 1'b1;
   reg PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
   reg [7:0] PADDR_IN = 8'h00;
   reg [31:0] PWDATA_IN = 32'h0;
   wire [31:0] PRDATA_OUT;
   wire PREADY_OUT, PSLVERR_OUT, IRQ_OUT, RXD_IN, busy;
   reg go = 1'b0, stop_low = 1'b0, glitch = 1'b0;
   reg [7:0] frame = 8'h00, ch, ch2;
   integer n_errors = 0, tests_run = 0, cycles = 0, seed = 15243, i;
   urf_exp_t q[$];
   urf_exp_t e;
   reg [31:0] tc[0:5];
   always #20 CLOCK_IN = ~CLOCK_IN;
   urf_rx_status DUT (.CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN),
      .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
      .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
      .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .RXD_IN(RXD_IN),
      .IRQ_OUT(IRQ_OUT));
   urf_serial_src u_src (.CLOCK_IN(CLOCK_IN), .go_in(go), .frame_in(frame),
      .stop_low_in(stop_low), .glitch_in(glitch), .RXD_OUT(RXD_IN),
      .busy_out(busy));
   task wrap_up;
      begin
         if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task miss(input string s);
      begin
         $display("mismatch at %0t: %s", $time, s);
         n_errors++;
      end
   endtask
   always @(posedge CLOCK_IN) begin
      cycles++;
      if (cycles == 20000) begin
         miss("timeout");
         wrap_up;
      end
   end
   // watcher: every bus answer takes the oldest note
   always @(posedge CLOCK_IN) begin
      if (!SYS_RST_IN && PREADY_OUT === 1'b1) cmp_bus;
   end
   task cmp_bus;
      begin
         if (q.size() == 0) miss("answer without request");
         else begin
            e = q.pop_front();
            tests_run++;
            if (((PRDATA_OUT ^ e.d) & e.m) !== 32'h0 || PSLVERR_OUT !== e.e)
               miss("bus answer");
         end
      end
   endtask
   task chk_irq(input logic x);
      begin
         tests_run++;
         if (IRQ_OUT !== x) miss("irq level");
      end
   endtask
   // holds the request until ready; a following setup may come at once
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            input logic [31:0] ed, input logic [31:0] em, input logic ee);
      integer t;
      begin
         PSEL_IN <= 1'b1;
         PENABLE_IN <= 1'b0;
         PWRITE_IN <= w;
         PADDR_IN <= a;
         PWDATA_IN <= wd;
         q.push_back('{ed, em, ee});
         @(posedge CLOCK_IN);
         PENABLE_IN <= 1'b1;
         t = 0;
         do begin
            @(posedge CLOCK_IN);
            t++;
         end while (PREADY_OUT !== 1'b1 && t < 50);
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] em);
      apb(1'b0, a, 32'h0, ed, em, 1'b0);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 32'h0, 32'h0, 1'b0);
   endtask
   task hold(input integer n);
      begin
         PSEL_IN <= 1'b0;
         PENABLE_IN <= 1'b0;
         repeat (n) @(posedge CLOCK_IN);
      end
   endtask
   task send(input logic [7:0] f, input logic g, input logic s);
      integer t;
      begin
         hold(0);
         frame <= f;
         glitch <= g;
         stop_low <= s;
         go <= 1'b1;
         @(posedge CLOCK_IN);
         go <= 1'b0;
         t = 0;
         do begin
            @(posedge CLOCK_IN);
            t++;
         end while (busy !== 1'b0 && t < 400);
         repeat (4) @(posedge CLOCK_IN);
      end
   endtask
   initial begin
      // ctrl, data, glitch, stop low, expected status
      tc[0] = 32'h10_00_10_24; tc[1] = 32'h10_00_01_22;
      tc[2] = 32'h11_01_00_21; tc[3] = 32'h11_03_00_20;
      tc[4] = 32'h13_03_00_21; tc[5] = 32'h13_01_00_20;
      repeat (5) @(posedge CLOCK_IN);
      SYS_RST_IN <= 1'b0;
      @(posedge CLOCK_IN);
      apb(1'b0, 8'h18, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
      wr(`URF_OFF_STATUS, 32'h3F);
      rd(`URF_OFF_STATUS, 32'h0, 32'h3F);
      wr(`URF_OFF_BAUD, 32'h1);
      ch = $random(seed);
      ch2 = $random(seed);
      send(ch, 1'b0, 1'b0);
      rd(`URF_OFF_STATUS, 32'h20, 32'h2F);
      send(ch2, 1'b0, 1'b0);
      rd(`URF_OFF_DATA, ch, 32'hFF);
      rd(`URF_OFF_STATUS, 32'h08, 32'h2F);
      rd(`URF_OFF_DATA, ch, 32'hFF);
      rd(`URF_OFF_STATUS, 32'h00, 32'h2F);
      for (i = 0; i < 6; i++) begin
         if (i == 0) tc[0][23:16] = $random(seed);
         if (i == 1) tc[1][23:16] = $random(seed);
         wr(`URF_OFF_CTRL, tc[i][31:24]);
         send(tc[i][23:16], tc[i][12], tc[i][8]);
         rd(`URF_OFF_STATUS, tc[i][7:0], 32'h2F);
         rd(`URF_OFF_DATA, tc[i][23:16], 32'hFF);
         rd(`URF_OFF_STATUS, 32'h0, 32'h2F);
      end
      // nine-bit mode: the model's stop bit lands as data bit 8
      wr(`URF_OFF_CTRL, 32'h14);
      ch = $random(seed);
      send(ch, 1'b0, 1'b0);
      hold(24);
      rd(`URF_OFF_STATUS, 32'h20, 32'h2F);
      rd(`URF_OFF_DATA, {23'h0, 1'b1, ch}, 32'h1FF);
      rd(`URF_OFF_STATUS, 32'h0, 32'h2F);
      for (i = 0; i < 2; i++) begin
         wr(`URF_OFF_CTRL, 32'h10 | (i << 3));
         send(8'hFF, 1'b0, 1'b0);
         hold(36);
         rd(`URF_OFF_STATUS, i ? 32'h20 : 32'h30, 32'h30);
         hold(170);
         rd(`URF_OFF_STATUS, 32'h30, 32'h30);
         rd(`URF_OFF_DATA, 32'hFF, 32'hFF);
         rd(`URF_OFF_STATUS, 32'h0, 32'h30);
         hold(200);
         rd(`URF_OFF_STATUS, 32'h0, 32'h10);
      end
      rd(`URF_OFF_INT_STAT, 32'h0, 32'h0);
      wr(`URF_OFF_INT_MASK, 32'h0);
      send($random(seed), 1'b0, 1'b0);
      chk_irq(1'b0);
      wr(`URF_OFF_INT_MASK, 32'h20);
      hold(3);
      chk_irq(1'b1);
      rd(`URF_OFF_INT_STAT, 32'h20, 32'h20);
      hold(3);
      chk_irq(1'b0);
      wrap_up;
   end
endmodule
